// ### hdl/crwu_map.svh
/*
  Register offsets, field positions, reset values and fixed counts of the
  clock, reset and watchdog unit.
  Assumes inclusion by bare name from the top module and the testbench.
*/
`ifndef CRWU_MAP_SVH
`define CRWU_MAP_SVH
`define CRWU_OFF_WDCTL 8'h00
`define CRWU_OFF_SERVICE 8'h04
`define CRWU_OFF_CLKSEL 8'h08
`define CRWU_OFF_PLLDIV 8'h0c
`define CRWU_OFF_STATUS 8'h10
`define CRWU_OFF_FACTORS 8'h14
`define CRWU_OFF_INTSTAT 8'h18
`define CRWU_OFF_INTCLR 8'h1c
`define CRWU_OFF_INTEN 8'h20
`define CRWU_WD_WIN 7
`define CRWU_WD_SDBG 6
`define CRWU_WD_MASK 5
`define CRWU_WD_RATE_HI 2
`define CRWU_CS_SEL0 0
`define CRWU_CS_SEL1 1
`define CRWU_CS_PSEUDO_STOP_SELECT 2
`define CRWU_CS_PCE 3
`define CRWU_CS_OSCILLATOR_ENABLE 4
`define CRWU_CS_PLL_SOURCE_SELECT 5
`define CRWU_PD_REF_LO 0
`define CRWU_PD_SYN_LO 8
`define CRWU_PD_POST_LO 16
`define CRWU_RATE_OFF 3'h0
`define CRWU_KEY_ARM 8'h55
`define CRWU_KEY_FIRE 8'haa
`define CRWU_RST_SEQ_LEN 10'h300
`define CRWU_POST_UNLOCKED 6'h04
`define CRWU_BUS_DIV 1'h1
`define CRWU_INT_WDOG 0
`define CRWU_INT_CMON 1
`define CRWU_ZERO32 32'h00000000
`endif

// ### hdl/crwu_pkg.sv
/*
  Types shared by the clock, reset and watchdog unit.
  Assumes the map header sits in the include path.
*/
package crwu_pkg;
  typedef logic [31:0] crwu_word_t;
  typedef logic [7:0] crwu_addr_t;
  typedef enum logic [0:0] {SVC_IDLE, SVC_ARMED} crwu_svc_t;
endpackage

// ### hdl/crwu_top.sv
/*
  Watchdog, divider chain, reset sequencer and clock monitor of the clock,
  reset and watchdog unit, with an APB slave for its registers.
  Assumes: reference, oscillator, auxiliary and VCO clocks arrive as pins far
  slower than CLK/2; nonvolatile defaults are stable at system reset release.
*/
// Summary of operation
// - Stop-in-debug clears only in special mode
// - Special mode: window/rate written when mask clear
// - Normal mode: window/rate written once, mask clear
// - Zero rate or window write consumes once
// - Nonzero loaded rate starts timeout period
// - Select change, or oscillator loss while the oscillator is the source, restarts period
// - Normal-mode effective writes or debug-bit rise restart
// - Special mode: any control write restarts
// - Counter source: auxiliary, RC or oscillator clock
// - Counter runs or halts in stop per selects
// - Timeout produces a system watchdog reset
// - Reference: RC, or oscillator over divider+1
// - VCO factor is two times multiplier+1
// - PLL output over post+1 locked, else four
// - Bus clock is half the PLL clock, or half the undivided oscillator/RC source edge when PLL source select is clear
// - Internal reset lasts 768 PLL clocks minimum
// - Oscillator loss gives clock-monitor reset when oscillator enabled, off in full stop
`timescale 1ns/1ps
`include "crwu_map.svh"
module crwu_top #(
  parameter int WD_W = 28,
  parameter int WD_BASE = 14,
  parameter int CM_LIMIT = 100
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire crwu_pkg::crwu_addr_t PADDR,
  input wire crwu_pkg::crwu_word_t PWDATA,
  output crwu_pkg::crwu_word_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ACLK_IN,
  input wire logic IRC_CLK_IN,
  input wire logic OSC_CLK_IN,
  input wire logic VCO_CLK_IN,
  input wire logic EXT_RESET_N,
  input wire logic PLL_LOCK,
  input wire logic OSC_UP,
  input wire logic SPECIAL_MODE,
  input wire logic STOP_MODE,
  input wire logic DEBUG_ACTIVE,
  input wire logic [2:0] NV_RATE,
  input wire logic NV_WINDOW,
  output logic SYS_RESET_N,
  output logic IRQ,
  output logic REF_TICK,
  output logic PLL_TICK,
  output logic BUS_TICK
);
  import crwu_pkg::*;

  localparam int NS = 10;

  // Two-stage synchronisers for every pin input
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  logic [NS-1:0] prev_r;
  assign pin_raw = {DEBUG_ACTIVE, STOP_MODE, SPECIAL_MODE, OSC_UP, PLL_LOCK,
                    EXT_RESET_N, VCO_CLK_IN, OSC_CLK_IN, IRC_CLK_IN, ACLK_IN};

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  wire [NS-1:0] rise = sync2_r & ~prev_r;
  wire aclk_edge = rise[0];
  wire irc_edge = rise[1];
  wire osc_edge = rise[2];
  wire vco_edge = rise[3];
  wire ext_rst = ~sync2_r[4];
  wire lock_s = sync2_r[5];
  wire oscillator_up_status_s = sync2_r[6];
  wire oscillator_up_status_fall = prev_r[6] & ~sync2_r[6];
  wire special = sync2_r[7];
  wire stop_s = sync2_r[8];
  wire debug_s = sync2_r[9];

  // Registers
  logic window_r;
  logic stop_dbg_r;
  logic [2:0] rate_r;
  logic once_used_r;
  logic [5:0] clksel_r;
  logic [3:0] refdiv_r;
  logic [5:0] syndiv_r;
  logic [4:0] postdiv_r;
  logic [1:0] int_stat_r;
  logic [1:0] int_en_r;
  logic wd_flag_r;
  logic cm_flag_r;
  crwu_svc_t svc_r;

  // APB slave: one wait state, answer registered
  wire access = PSEL & PENABLE;
  wire done = access & PREADY;
  wire wr = done & PWRITE;
  wire sel_wdctl = (PADDR == `CRWU_OFF_WDCTL);
  wire sel_service = (PADDR == `CRWU_OFF_SERVICE);
  wire sel_clksel = (PADDR == `CRWU_OFF_CLKSEL);
  wire sel_plldiv = (PADDR == `CRWU_OFF_PLLDIV);
  wire sel_status = (PADDR == `CRWU_OFF_STATUS);
  wire sel_factors = (PADDR == `CRWU_OFF_FACTORS);
  wire sel_intstat = (PADDR == `CRWU_OFF_INTSTAT);
  wire sel_intclr = (PADDR == `CRWU_OFF_INTCLR);
  wire sel_inten = (PADDR == `CRWU_OFF_INTEN);
  wire mapped = sel_wdctl | sel_service | sel_clksel | sel_plldiv | sel_status |
                sel_factors | sel_intstat | sel_intclr | sel_inten;

  wire sel0 = clksel_r[`CRWU_CS_SEL0];
  wire sel1 = clksel_r[`CRWU_CS_SEL1];
  wire pseudo_stop_select = clksel_r[`CRWU_CS_PSEUDO_STOP_SELECT];
  wire wdog_pseudo_stop_enable = clksel_r[`CRWU_CS_PCE];
  wire oscillator_enable = clksel_r[`CRWU_CS_OSCILLATOR_ENABLE];
  wire pll_source_select = clksel_r[`CRWU_CS_PLL_SOURCE_SELECT];

  // Divider factors
  wire [4:0] ref_factor = {1'b0, refdiv_r} + 5'h01;
  wire [7:0] vco_factor = {1'b0, syndiv_r, 1'b0} + 8'h02;
  wire [5:0] post_factor = lock_s ? ({1'b0, postdiv_r} + 6'h01) : `CRWU_POST_UNLOCKED;

  // Control register write qualification
  wire wd_write = wr & sel_wdctl;
  wire [2:0] wr_rate = PWDATA[`CRWU_WD_RATE_HI:0];
  wire wr_win = PWDATA[`CRWU_WD_WIN];
  wire wr_sdbg = PWDATA[`CRWU_WD_SDBG];
  wire wr_mask = PWDATA[`CRWU_WD_MASK];
  wire wd_allowed = wd_write & ~wr_mask & (special | ~once_used_r);
  wire rate_take = wd_allowed & (special | (wr_rate != `CRWU_RATE_OFF));
  wire win_take = wd_allowed & (special | wr_win);
  wire sdbg_nxt = special ? wr_sdbg : (stop_dbg_r | wr_sdbg);
  wire sdbg_rise = wd_write & ~stop_dbg_r & sdbg_nxt;
  wire restart_normal = ~special & (sdbg_rise |
                        (wd_allowed & ((wr_rate != `CRWU_RATE_OFF) | wr_win)));
  wire restart_special = special & wd_write;
  wire clksel_write = wr & sel_clksel;
  wire sel_changed = clksel_write & ((PWDATA[`CRWU_CS_SEL0] != sel0) |
                                     (PWDATA[`CRWU_CS_SEL1] != sel1));
  wire restart_sel = sel_changed | (oscillator_up_status_fall & ~sel1 & sel0);

  // Reset sequencer state
  logic [9:0] seq_cnt_r;
  logic sys_rst_r;
  wire seq_running = (seq_cnt_r != `CRWU_RST_SEQ_LEN);
  wire nv_load = sys_rst_r & ~seq_running & ~ext_rst;
  wire restart_nv = nv_load & (NV_RATE != `CRWU_RATE_OFF);

  // Watchdog counter
  logic [WD_W-1:0] wd_cnt_r;
  function automatic logic [WD_W-1:0] period_of(input logic [2:0] r);
    int sh;
    sh = WD_BASE + 2 * (int'(r) - 1);
    return WD_W'(64'h1 << sh);
  endfunction
  wire [WD_W-1:0] period = period_of(rate_r);
  wire [WD_W-1:0] window_open = period - (period >> 2);
  wire wd_src_edge = sel1 ? aclk_edge : (sel0 ? osc_edge : irc_edge);
  wire full_stop = stop_s & ~pseudo_stop_select;
  wire run_in_stop = (pseudo_stop_select & sel0 & ~sel1 & wdog_pseudo_stop_enable) | sel1;
  wire wd_halt = (stop_s & ~run_in_stop) | (stop_dbg_r & debug_s);
  wire wd_enabled = (rate_r != `CRWU_RATE_OFF) & ~sys_rst_r;
  wire wd_expire = wd_enabled & ~wd_halt & wd_src_edge & (wd_cnt_r == period - WD_W'(1));

  // Service sequence: arm key then fire key; early fire in window mode is fatal
  wire svc_write = wr & sel_service & wd_enabled;
  wire svc_arm = svc_write & (PWDATA[7:0] == `CRWU_KEY_ARM);
  wire svc_fire = svc_write & (PWDATA[7:0] == `CRWU_KEY_FIRE) & (svc_r == SVC_ARMED);
  wire svc_bad = svc_write & ~svc_arm & ~svc_fire;
  wire svc_early = svc_fire & window_r & (wd_cnt_r < window_open);
  wire svc_ok = svc_fire & ~svc_early;
  wire wd_fire = wd_expire | svc_bad | svc_early;
  wire wd_restart = restart_normal | restart_special | restart_sel | restart_nv | svc_ok;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      svc_r <= SVC_IDLE;
    else if (svc_arm)
      svc_r <= SVC_ARMED;
    else if (svc_write | wd_restart)
      svc_r <= SVC_IDLE;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      wd_cnt_r <= '0;
    else if (wd_restart | ~wd_enabled | wd_expire)
      wd_cnt_r <= '0;
    else if (wd_src_edge & ~wd_halt)
      wd_cnt_r <= wd_cnt_r + WD_W'(1);
  end

  // Clock monitor: oscillator edge missing for CM_LIMIT cycles
  logic [15:0] cm_cnt_r;
  wire cm_active = oscillator_enable & ~full_stop & ~sys_rst_r;
  wire cm_fire = cm_active & (cm_cnt_r == 16'(CM_LIMIT));

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      cm_cnt_r <= '0;
    else if (~cm_active | osc_edge | cm_fire)
      cm_cnt_r <= '0;
    else
      cm_cnt_r <= cm_cnt_r + 16'h0001;
  end

  // Reference, PLL and bus dividers
  logic [4:0] ref_cnt_r;
  logic [5:0] post_cnt_r;
  logic bus_ph_r;
  wire ref_src = oscillator_enable ? osc_edge : irc_edge;
  wire ref_hit = ref_src & (~oscillator_enable | (ref_cnt_r == ref_factor - 5'h01));
  wire pll_hit = vco_edge & (post_cnt_r >= post_factor - 6'h01);
  wire bus_src = pll_source_select ? pll_hit : ref_src;
  wire bus_hit = bus_src & (bus_ph_r == `CRWU_BUS_DIV);

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ref_cnt_r <= '0;
      post_cnt_r <= '0;
      bus_ph_r <= 1'b0;
    end
    else
    begin
      if (ref_src)
        ref_cnt_r <= ref_hit ? 5'h00 : ref_cnt_r + 5'h01;
      if (vco_edge)
        post_cnt_r <= pll_hit ? 6'h00 : post_cnt_r + 6'h01;
      if (bus_src)
        bus_ph_r <= ~bus_ph_r;
    end
  end

  // Reset sequencer counts PLL ticks after every source releases
  wire rst_src = wd_fire | cm_fire | ext_rst;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      seq_cnt_r <= '0;
      sys_rst_r <= 1'b1;
    end
    else if (rst_src)
    begin
      seq_cnt_r <= '0;
      sys_rst_r <= 1'b1;
    end
    else if (seq_running)
    begin
      if (pll_hit)
        seq_cnt_r <= seq_cnt_r + 10'h001;
    end
    else
      sys_rst_r <= 1'b0;
  end

  // Watchdog control register
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      window_r <= 1'b0;
      rate_r <= `CRWU_RATE_OFF;
      stop_dbg_r <= 1'b0;
      once_used_r <= 1'b0;
    end
    else if (nv_load)
    begin
      window_r <= NV_WINDOW;
      rate_r <= NV_RATE;
      stop_dbg_r <= 1'b0;
      once_used_r <= 1'b0;
    end
    else if (wd_write)
    begin
      stop_dbg_r <= sdbg_nxt;
      if (rate_take)
        rate_r <= wr_rate;
      if (win_take)
        window_r <= wr_win;
      if (wd_allowed & ~special)
        once_used_r <= 1'b1;
    end
  end

  // Clock and divider configuration
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      clksel_r <= '0;
      refdiv_r <= '0;
      syndiv_r <= '0;
      postdiv_r <= '0;
      int_en_r <= '0;
    end
    else
    begin
      if (clksel_write)
        clksel_r <= PWDATA[5:0];
      if (wr & sel_plldiv)
      begin
        refdiv_r <= PWDATA[`CRWU_PD_REF_LO +: 4];
        syndiv_r <= PWDATA[`CRWU_PD_SYN_LO +: 6];
        postdiv_r <= PWDATA[`CRWU_PD_POST_LO +: 5];
      end
      if (wr & sel_inten)
        int_en_r <= PWDATA[1:0];
    end
  end

  // Sticky events: a new event beats a simultaneous clear
  wire [1:0] events = {cm_fire, wd_fire};
  wire [1:0] int_clr = (wr & sel_intclr) ? PWDATA[1:0] : 2'h0;
  wire [1:0] int_stat_nxt = (int_stat_r & ~int_clr) | events;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      int_stat_r <= '0;
      wd_flag_r <= 1'b0;
      cm_flag_r <= 1'b0;
      IRQ <= 1'b0;
    end
    else
    begin
      int_stat_r <= int_stat_nxt;
      wd_flag_r <= wd_flag_r | wd_fire;
      cm_flag_r <= cm_flag_r | cm_fire;
      IRQ <= |(int_stat_nxt & int_en_r);
    end
  end

  // Read multiplexer
  wire [31:0] rd_wdctl = {24'h000000, window_r, stop_dbg_r, 3'h0, rate_r};
  wire [31:0] rd_status = {27'h0000000, once_used_r, oscillator_up_status_s, lock_s, cm_flag_r, wd_flag_r};
  wire [31:0] rd_factors = {10'h000, post_factor, vco_factor, 3'h0, ref_factor};
  wire [31:0] rd_plldiv = {11'h000, postdiv_r, 2'h0, syndiv_r, 4'h0, refdiv_r};
  wire [31:0] rd_data =
    sel_wdctl ? rd_wdctl :
    sel_clksel ? {26'h0000000, clksel_r} :
    sel_plldiv ? rd_plldiv :
    sel_status ? rd_status :
    sel_factors ? rd_factors :
    sel_intstat ? {30'h00000000, int_stat_r} :
    sel_inten ? {30'h00000000, int_en_r} :
    `CRWU_ZERO32;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= access & ~PREADY;
      PSLVERR <= access & ~PREADY & ~mapped;
      if (access & ~PREADY & ~PWRITE)
        PRDATA <= rd_data;
    end
  end

  // Outputs
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      SYS_RESET_N <= 1'b0;
      REF_TICK <= 1'b0;
      PLL_TICK <= 1'b0;
      BUS_TICK <= 1'b0;
    end
    else
    begin
      SYS_RESET_N <= ~sys_rst_r;
      REF_TICK <= ref_hit;
      PLL_TICK <= pll_hit;
      BUS_TICK <= bus_hit;
    end
  end
endmodule // crwu_top

// ### testbench/crwu_properties.sv
/* Port assertions for the clock, reset and watchdog unit.
   Assumes binding into crwu_top, one clock CLK and reset NRST. */
`timescale 1ns/1ps
module crwu_properties (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire crwu_pkg::crwu_addr_t PADDR,
  input wire crwu_pkg::crwu_word_t PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic EXT_RESET_N,
  input wire logic SYS_RESET_N,
  input wire logic REF_TICK,
  input wire logic PLL_TICK
);
  import crwu_pkg::*;
  logic [9:0] ticks_r;
  logic [9:0] ticks_nxt;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // PLL ticks seen while the system is held, saturating
  assign ticks_nxt = SYS_RESET_N ? 10'h000 : ticks_r + {9'h000, PLL_TICK & ~&ticks_r};
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
      ticks_r <= 10'h000;
    else
      ticks_r <= ticks_nxt;
  pready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  ready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  err_map_a: assert property (PREADY |-> PSLVERR == (PADDR > 8'h20 || PADDR[1:0] != 2'h0))
    else $error("error response wrong");
  rdata_hold_a: assert property (!$stable(PRDATA) |-> PREADY && !PWRITE)
    else $error("read data moved");
  reset_len_a: assert property ($rose(SYS_RESET_N) |-> ticks_r >= 10'h2ff)
    else $error("reset sequence short");
  ext_hold_a: assert property (!EXT_RESET_N [*5] |-> !SYS_RESET_N)
    else $error("reset released with pin low");
  ref_pulse_a: assert property (REF_TICK |=> !REF_TICK [*2])
    else $error("reference tick too wide");
  pll_pulse_a: assert property (PLL_TICK |=> !PLL_TICK [*2])
    else $error("pll tick too wide");
endmodule // crwu_properties
bind crwu_top crwu_properties u_props (.CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PRDATA, .PREADY, .PSLVERR, .EXT_RESET_N, .SYS_RESET_N, .REF_TICK, .PLL_TICK);

// ### testbench/testbench.sv
/* Self-checking bench for the clock, reset and watchdog unit.
   Assumes design files and checker compiled first. */
`timescale 1ns/1ps
`include "crwu_map.svh"
module testbench;
  import crwu_pkg::*;
  logic CLK = 0;
  logic NRST = 0;
  logic PSEL = 0;
  logic PENABLE = 0;
  logic PWRITE = 0;
  crwu_addr_t PADDR = 8'h00;
  crwu_word_t PWDATA = 32'h0;
  crwu_word_t PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic ACLK_IN = 0;
  logic IRC_CLK_IN = 0;
  logic OSC_CLK_IN = 0;
  logic VCO_CLK_IN = 0;
  logic EXT_RESET_N = 1;
  logic PLL_LOCK = 0;
  logic OSC_UP = 1;
  logic SPECIAL_MODE = 0;
  logic STOP_MODE = 0;
  logic DEBUG_ACTIVE = 0;
  logic [2:0] NV_RATE = 3'h0;
  logic NV_WINDOW = 0;
  logic SYS_RESET_N;
  logic IRQ;
  logic REF_TICK;
  logic PLL_TICK;
  logic BUS_TICK;
  logic osc_run = 1;
  logic [3:0] ph = 4'h0;
  logic rerr;
  crwu_word_t rdat;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int i;
  int n;
  crwu_top #(.WD_BASE(2), .CM_LIMIT(20)) u_dut (.CLK, .NRST, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ACLK_IN, .IRC_CLK_IN, .OSC_CLK_IN,
    .VCO_CLK_IN, .EXT_RESET_N, .PLL_LOCK, .OSC_UP, .SPECIAL_MODE, .STOP_MODE,
    .DEBUG_ACTIVE, .NV_RATE, .NV_WINDOW, .SYS_RESET_N, .IRQ, .REF_TICK, .PLL_TICK,
    .BUS_TICK);
  initial forever #50 CLK = ~CLK;
  // Slow source clocks made from CLK: VCO and oscillator period 4, RC 8, auxiliary 16
  always @(posedge CLK)
  begin
    ph <= ph + 4'h1;
    VCO_CLK_IN <= ph[1];
    OSC_CLK_IN <= ph[1] & osc_run;
    IRC_CLK_IN <= ph[2];
    ACLK_IN <= ph[3];
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fails++;
      $display("ERROR %0t run timed out", $time);
      complete_run();
    end
  end
  task automatic chk(input crwu_word_t g, input crwu_word_t e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input crwu_addr_t a, input crwu_word_t d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Request stands until ready is seen high at a rising edge
    do
      @(posedge CLK);
    while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input crwu_addr_t a, input crwu_word_t d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input crwu_addr_t a, input crwu_word_t e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // Wait up to m cycles for reset level v, then compare against e
  task automatic ws(input logic v, input int m, input logic e);
    int k;
    for (k = 0; k < m && SYS_RESET_N !== v; k++)
      @(posedge CLK);
    chk({31'h0, SYS_RESET_N}, {31'h0, e});
  endtask
  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask
  initial
  begin
    repeat (5) @(posedge CLK);
    NRST <= 1'b1;
    EXT_RESET_N <= 1'b0;
    repeat (8) @(posedge CLK);
    EXT_RESET_N <= 1'b1;
    ws(1'b1, 20000, 1'b1);
    rc(`CRWU_OFF_WDCTL, 32'h0);
    ws(1'b0, 1000, 1'b1);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    tend("reset");
    wr(`CRWU_OFF_WDCTL, 32'h60);
    rc(`CRWU_OFF_WDCTL, 32'h40);
    rc(`CRWU_OFF_STATUS, 32'h08);
    wr(`CRWU_OFF_WDCTL, 32'h20);
    rc(`CRWU_OFF_WDCTL, 32'h40);
    wr(`CRWU_OFF_WDCTL, 32'h00);
    rc(`CRWU_OFF_STATUS, 32'h18);
    wr(`CRWU_OFF_WDCTL, 32'h83);
    rc(`CRWU_OFF_WDCTL, 32'h40);
    tend("normal mode");
    SPECIAL_MODE <= 1'b1;
    repeat (4) @(posedge CLK);
    wr(`CRWU_OFF_WDCTL, 32'h63);
    rc(`CRWU_OFF_WDCTL, 32'h40);
    wr(`CRWU_OFF_WDCTL, 32'h03);
    rc(`CRWU_OFF_WDCTL, 32'h03);
    wr(`CRWU_OFF_INTEN, 32'h1);
    // Masked writes only restart the period
    repeat (4)
    begin
      repeat (250) @(posedge CLK);
      wr(`CRWU_OFF_WDCTL, 32'h23);
    end
    chk({31'h0, SYS_RESET_N}, 32'h1);
    STOP_MODE <= 1'b1;
    ws(1'b0, 800, 1'b1);
    wr(`CRWU_OFF_CLKSEL, 32'h2);
    ws(1'b0, 1500, 1'b0);
    repeat (4) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h1);
    rc(`CRWU_OFF_INTSTAT, 32'h1);
    wr(`CRWU_OFF_INTEN, 32'h0);
    repeat (2) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h0);
    wr(`CRWU_OFF_INTCLR, 32'h1);
    rc(`CRWU_OFF_INTSTAT, 32'h0);
    STOP_MODE <= 1'b0;
    NV_RATE <= 3'h3;
    tend("special mode");
    ws(1'b1, 20000, 1'b1);
    rc(`CRWU_OFF_WDCTL, 32'h03);
    ws(1'b0, 1500, 1'b0);
    NV_RATE <= 3'h0;
    ws(1'b1, 20000, 1'b1);
    tend("loaded rate");
    wr(`CRWU_OFF_CLKSEL, 32'h10);
    ws(1'b0, 300, 1'b1);
    osc_run <= 1'b0;
    ws(1'b0, 300, 1'b0);
    osc_run <= 1'b1;
    rc(`CRWU_OFF_INTSTAT, 32'h3);
    wr(`CRWU_OFF_CLKSEL, 32'h0);
    ws(1'b1, 20000, 1'b1);
    tend("clock monitor");
    wr(`CRWU_OFF_PLLDIV, 32'h001f3f0f);
    rc(`CRWU_OFF_FACTORS, {10'h0, `CRWU_POST_UNLOCKED, 8'(2 * (6'h3f + 1)), 3'h0,
      5'(4'hf + 1)});
    PLL_LOCK <= 1'b1;
    repeat (4) @(posedge CLK);
    rc(`CRWU_OFF_FACTORS, {10'h0, 6'(5'h1f + 1), 8'h80, 3'h0, 5'h10});
    wr(`CRWU_OFF_PLLDIV, 32'h00010000);
    wr(`CRWU_OFF_CLKSEL, 32'h20);
    for (i = 0; i < 200 && BUS_TICK !== 1'b1; i++)
      @(negedge CLK);
    n = 0;
    do
    begin
      @(negedge CLK);
      n += PLL_TICK;
    end
    while (BUS_TICK !== 1'b1 && n < 9);
    chk(32'(n), 32'h2);
    wr(`CRWU_OFF_PLLDIV, 32'h00010003);
    wr(`CRWU_OFF_CLKSEL, 32'h30);
    for (i = 0; i < 200 && REF_TICK !== 1'b1; i++)
      @(negedge CLK);
    n = 0;
    do
    begin
      @(negedge CLK);
      n++;
    end
    while (REF_TICK !== 1'b1 && n < 99);
    chk(32'(n), 32'(4 * (3 + 1)));
    tend("dividers");
    complete_run();
  end
endmodule // testbench
